// File: hdl/cff_pkg.sv
// Package of register map, field layout and operation codes for the flag unit
package cff_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_OPERAND_A = 8'h04;
  localparam logic [7:0] REG_OPERAND_B = 8'h08;
  localparam logic [7:0] REG_RESULT = 8'h0c;
  localparam logic [7:0] REG_FLAGS = 8'h10;
  localparam logic [7:0] REG_ADDR_IN = 8'h14;
  localparam logic [7:0] REG_ADDR_OUT = 8'h18;
  localparam logic [7:0] REG_FLAGS_AND = 8'h1c;
  localparam logic [7:0] REG_FLAGS_OR = 8'h20;
  localparam logic [7:0] REG_FLAGS_XOR = 8'h24;

  ////////////////////////////////////////////////////////////////////////////
  // Control and address input register fields
  localparam int CTRL_OP_LSB = 0;
  localparam int CTRL_SIZE_LSB = 4;
  localparam int CTRL_BIT_LSB = 8;
  localparam int ADDR_KIND_LSB = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Flag bit positions and reset value
  localparam int FLAG_IMASK = 7;
  localparam int FLAG_USER = 4;
  localparam int FLAG_NEG = 3;
  localparam int FLAG_ZERO = 2;
  localparam int FLAG_OVF = 1;
  localparam int FLAG_CARRY = 0;
  localparam logic FLAG_IMASK_RESET = 1'b1;

  ////////////////////////////////////////////////////////////////////////////
  // Operand sizes and memory access kinds
  localparam logic [1:0] SZ_BYTE = 2'h0;
  localparam logic [1:0] SZ_WORD = 2'h1;
  localparam logic [1:0] SZ_LONG = 2'h2;
  localparam logic [1:0] ACC_BYTE = 2'h0;
  localparam logic [1:0] ACC_WORD = 2'h1;
  localparam logic [1:0] ACC_LONG = 2'h2;
  localparam logic [1:0] ACC_FETCH = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // Operations
  localparam logic [3:0] OP_ADD = 4'h0;
  localparam logic [3:0] OP_ADDX = 4'h1;
  localparam logic [3:0] OP_SUB = 4'h2;
  localparam logic [3:0] OP_SUBX = 4'h3;
  localparam logic [3:0] OP_AND = 4'h4;
  localparam logic [3:0] OP_SHL = 4'h5;
  localparam logic [3:0] OP_SHR = 4'h6;
  localparam logic [3:0] OP_ROTL = 4'h7;
  localparam logic [3:0] OP_ROTR = 4'h8;
  localparam logic [3:0] OP_BLD = 4'h9;
  localparam logic [3:0] OP_BST = 4'ha;
  localparam logic [3:0] OP_BAND = 4'hb;
  localparam logic [3:0] OP_BOR = 4'hc;
  localparam logic [3:0] OP_BXOR = 4'hd;
  localparam logic [3:0] OP_DECIMAL_ADJUST_ADD = 4'he;
  localparam logic [3:0] OP_DECIMAL_ADJUST_SUB = 4'hf;

  localparam logic [7:0] BCD_LOW_FIX = 8'h06;
  localparam logic [7:0] BCD_HIGH_FIX = 8'h60;
  localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
  localparam logic [7:0] BCD_BYTE_MAX = 8'h99;

endpackage : cff_pkg

// File: hdl/cff_addr_align.sv
// Memory address former that forces even addresses for word, longword and fetch
`timescale 1ns/10ps
`default_nettype none
module cff_addr_align #(
  parameter int ADDR_WIDTH = 16
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_load,
  input wire logic [ADDR_WIDTH-1:0] i_addr,
  input wire logic [1:0] i_kind,
  output logic [ADDR_WIDTH-1:0] o_addr
);
  import cff_pkg::*;

  // Bit 0 is dropped and the bits above it kept, so a one-bit address cannot work
  if (ADDR_WIDTH < 2) begin : g_width_check
    $error("cff_addr_align: ADDR_WIDTH must be at least 2");
  end

  // No address error is raised: an odd address of any kind but byte simply drops bit 0
  wire logic force_even;
  wire logic [ADDR_WIDTH-1:0] next_addr;
  assign force_even = (i_kind != ACC_BYTE);
  assign next_addr = force_even ? {i_addr[ADDR_WIDTH-1:1], 1'b0} : i_addr;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_addr <= '0;
    end else if (i_load) begin
      o_addr <= next_addr;
    end
  end

endmodule : cff_addr_align
`default_nettype wire

// File: hdl/cff_flag_unit.sv
// Condition flag unit with operand formatting, reached over APB
//
// The placing of the registers and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
// Notes on behaviour
// - Flag bit 4 is a user bit, software reads and writes it freely.
// - Negative flag bit 3 takes the result sign at the operand size.
// - Zero flag bit 2 is set for an all-zero result, cleared otherwise.
// - Overflow flag bit 1 set on arithmetic overflow, cleared otherwise except by bit operations and decimal adjust.
// - Carry flag bit 0 set on carry out of the operand top bit.
// - Subtractions record a borrow in the carry flag.
// - Shifts and rotates load carry with the bit shifted out.
// - Bit operations use carry as one-bit accumulator source and destination.
// - Operands of 1, 8, 16 and 32 bits are handled.
// - Bit operations pick bit 0 to 7 of a byte and touch only it.
// - Decimal adjust treats a byte as two packed BCD digits.
// - Odd word or longword access raises no error, bit 0 forced low.
// - Instruction fetches force address bit 0 low the same way.
// - Reset sets interrupt mask bit 7, other flag bits stay uninitialised.
// - Flags an operation does not affect keep their previous values.
module cff_flag_unit (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic o_pready,
  output logic [31:0] o_prdata,
  output logic o_pslverr,
  output logic [15:0] o_mem_addr,
  output logic o_flag_carry
);
  import cff_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic [31:0] size_mask(input logic [1:0] s);
    if (s == SZ_BYTE) begin
      size_mask = 32'h0000_00ff;
    end else if (s == SZ_WORD) begin
      size_mask = 32'h0000_ffff;
    end else begin
      size_mask = 32'hffff_ffff;
    end
  endfunction : size_mask

  function automatic logic top_bit(input logic [1:0] s, input logic [32:0] v);
    if (s == SZ_BYTE) begin
      top_bit = v[7];
    end else if (s == SZ_WORD) begin
      top_bit = v[15];
    end else begin
      top_bit = v[31];
    end
  endfunction : top_bit

  function automatic logic carry_out(input logic [1:0] s, input logic [32:0] v);
    if (s == SZ_BYTE) begin
      carry_out = v[8];
    end else if (s == SZ_WORD) begin
      carry_out = v[16];
    end else begin
      carry_out = v[32];
    end
  endfunction : carry_out

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [3:0] ctrl_op;
  logic [1:0] ctrl_size;
  logic [2:0] ctrl_bit;
  logic [31:0] operand_a;
  logic [31:0] operand_b;
  logic [31:0] result;
  logic flag_imask;
  logic [6:0] flag_low;
  logic [15:0] addr_in;
  logic [1:0] addr_kind;
  logic addr_load;
  wire logic [15:0] aligned_addr;

  wire logic [7:0] flags;
  assign flags = {flag_imask, flag_low};

  ////////////////////////////////////////////////////////////////////////////
  // APB decode
  wire logic setup;
  wire logic wr_en;
  wire logic do_op;
  wire logic hit;
  wire logic [31:0] rd_value;
  assign setup = i_psel && !i_penable;
  assign wr_en = i_psel && i_penable && i_pwrite && o_pready;
  assign do_op = wr_en && (i_paddr == REG_CTRL);
  assign hit = (i_paddr == REG_CTRL) || (i_paddr == REG_OPERAND_A) || (i_paddr == REG_OPERAND_B)
    || (i_paddr == REG_RESULT) || (i_paddr == REG_FLAGS) || (i_paddr == REG_ADDR_IN)
    || (i_paddr == REG_ADDR_OUT) || (i_paddr == REG_FLAGS_AND) || (i_paddr == REG_FLAGS_OR)
    || (i_paddr == REG_FLAGS_XOR);
  assign rd_value = (i_paddr == REG_CTRL) ? {21'h0, ctrl_bit, 2'h0, ctrl_size, ctrl_op}
    : (i_paddr == REG_OPERAND_A) ? operand_a
    : (i_paddr == REG_OPERAND_B) ? operand_b
    : (i_paddr == REG_RESULT) ? result
    : (i_paddr == REG_FLAGS) ? {24'h0, flags}
    : (i_paddr == REG_ADDR_IN) ? {14'h0, addr_kind, addr_in}
    : (i_paddr == REG_ADDR_OUT) ? {16'h0, aligned_addr}
    : 32'h0000_0000;

  ////////////////////////////////////////////////////////////////////////////
  // Operation datapath, evaluated on the operands as they stand
  wire logic [3:0] op;
  wire logic [1:0] sz;
  wire logic [2:0] bsel;
  wire logic [31:0] mask;
  wire logic [31:0] a;
  wire logic [31:0] b;
  wire logic cin;
  wire logic use_cin;
  wire logic [32:0] sum;
  wire logic [32:0] diff;
  wire logic sel_bit;
  wire logic [31:0] top_mask;
  wire logic [7:0] bcd;
  wire logic bcd_low;
  wire logic bcd_high;
  assign op = i_pwdata[CTRL_OP_LSB +: 4];
  assign sz = i_pwdata[CTRL_SIZE_LSB +: 2];
  assign bsel = i_pwdata[CTRL_BIT_LSB +: 3];
  assign mask = size_mask(sz);
  assign a = operand_a & mask;
  assign b = operand_b & mask;
  assign cin = flag_low[FLAG_CARRY];
  assign use_cin = (op == OP_ADDX) || (op == OP_SUBX);
  assign sum = {1'b0, a} + {1'b0, b} + {32'h0, use_cin & cin};
  assign diff = {1'b0, a} - {1'b0, b} - {32'h0, use_cin & cin};
  assign sel_bit = operand_a[bsel];
  assign top_mask = mask ^ (mask >> 1);
  // BCD digits of the low byte; half-carry is not kept, so digits above 9 steer the fix
  assign bcd = operand_a[7:0];
  assign bcd_low = bcd[3:0] > BCD_DIGIT_MAX;
  assign bcd_high = cin || (bcd > BCD_BYTE_MAX);

  logic [31:0] next_result;
  logic [3:0] next_nzvc;
  always_comb begin
    next_result = result;
    next_nzvc = flag_low[3:0];
    case (op)
      OP_ADD, OP_ADDX: begin
        next_result = sum[31:0] & mask;
        next_nzvc[FLAG_CARRY] = carry_out(sz, sum);
        next_nzvc[FLAG_OVF] = (top_bit(sz, {1'b0, a}) == top_bit(sz, {1'b0, b}))
          && (top_bit(sz, sum) != top_bit(sz, {1'b0, a}));
      end
      OP_SUB, OP_SUBX: begin
        next_result = diff[31:0] & mask;
        next_nzvc[FLAG_CARRY] = carry_out(sz, diff);
        next_nzvc[FLAG_OVF] = (top_bit(sz, {1'b0, a}) != top_bit(sz, {1'b0, b}))
          && (top_bit(sz, diff) != top_bit(sz, {1'b0, a}));
      end
      OP_AND: begin
        next_result = a & b;
        next_nzvc[FLAG_OVF] = 1'b0;
      end
      OP_SHL, OP_ROTL: begin
        next_result = ((a << 1) | ((op == OP_ROTL && top_bit(sz, {1'b0, a})) ? 32'h1 : 32'h0)) & mask;
        next_nzvc[FLAG_CARRY] = top_bit(sz, {1'b0, a});
        next_nzvc[FLAG_OVF] = 1'b0;
      end
      OP_SHR, OP_ROTR: begin
        next_result = (a >> 1) | ((op == OP_ROTR && a[0]) ? top_mask : 32'h0);
        next_nzvc[FLAG_CARRY] = a[0];
        next_nzvc[FLAG_OVF] = 1'b0;
      end
      OP_BLD: begin
        next_nzvc[FLAG_CARRY] = sel_bit;
      end
      OP_BST: begin
        next_result = {24'h0, operand_a[7:0]};
        next_result[bsel] = cin;
      end
      OP_BAND: begin
        next_nzvc[FLAG_CARRY] = cin & sel_bit;
      end
      OP_BOR: begin
        next_nzvc[FLAG_CARRY] = cin | sel_bit;
      end
      OP_BXOR: begin
        next_nzvc[FLAG_CARRY] = cin ^ sel_bit;
      end
      OP_DECIMAL_ADJUST_ADD: begin
        next_result = {24'h0, bcd + (bcd_low ? BCD_LOW_FIX : 8'h00) + (bcd_high ? BCD_HIGH_FIX : 8'h00)};
        next_nzvc[FLAG_CARRY] = bcd_high;
      end
      default: begin
        next_result = {24'h0, bcd - (bcd_low ? BCD_LOW_FIX : 8'h00) - (cin ? BCD_HIGH_FIX : 8'h00)};
      end
    endcase
    // Bit operations report no sign or zero; everything else does
    if (!(op inside {OP_BLD, OP_BST, OP_BAND, OP_BOR, OP_BXOR})) begin
      next_nzvc[FLAG_NEG] = (op == OP_DECIMAL_ADJUST_ADD || op == OP_DECIMAL_ADJUST_SUB) ? next_result[7]
        : top_bit(sz, {1'b0, next_result});
      next_nzvc[FLAG_ZERO] = (next_result == 32'h0);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Flag register: only the mask bit has a reset value
  logic [6:0] next_flag_low;
  logic next_flag_imask;
  assign next_flag_low = !wr_en ? flag_low
    : (i_paddr == REG_FLAGS) ? i_pwdata[6:0]
    : (i_paddr == REG_FLAGS_AND) ? flag_low & i_pwdata[6:0]
    : (i_paddr == REG_FLAGS_OR) ? flag_low | i_pwdata[6:0]
    : (i_paddr == REG_FLAGS_XOR) ? flag_low ^ i_pwdata[6:0]
    : do_op ? {flag_low[6:4], next_nzvc}
    : flag_low;
  assign next_flag_imask = !wr_en ? flag_imask
    : (i_paddr == REG_FLAGS) ? i_pwdata[FLAG_IMASK]
    : (i_paddr == REG_FLAGS_AND) ? flag_imask & i_pwdata[FLAG_IMASK]
    : (i_paddr == REG_FLAGS_OR) ? flag_imask | i_pwdata[FLAG_IMASK]
    : (i_paddr == REG_FLAGS_XOR) ? flag_imask ^ i_pwdata[FLAG_IMASK]
    : flag_imask;

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      flag_imask <= FLAG_IMASK_RESET;
    end else begin
      flag_imask <= next_flag_imask;
    end
  end

  // Left without reset on purpose, so software must not trust these after reset
  always_ff @(posedge i_clock) begin
    flag_low <= next_flag_low;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Operand and control registers
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      ctrl_op <= OP_ADD;
      ctrl_size <= SZ_BYTE;
      ctrl_bit <= 3'h0;
      operand_a <= 32'h0;
      operand_b <= 32'h0;
      result <= 32'h0;
    end else begin
      if (do_op) begin
        ctrl_op <= op;
        ctrl_size <= sz;
        ctrl_bit <= bsel;
        result <= next_result;
      end
      if (wr_en && i_paddr == REG_OPERAND_A) begin
        operand_a <= i_pwdata;
      end
      if (wr_en && i_paddr == REG_OPERAND_B) begin
        operand_b <= i_pwdata;
      end
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      addr_in <= 16'h0;
      addr_kind <= ACC_BYTE;
      addr_load <= 1'b0;
    end else begin
      addr_load <= wr_en && (i_paddr == REG_ADDR_IN);
      if (wr_en && i_paddr == REG_ADDR_IN) begin
        addr_in <= i_pwdata[15:0];
        addr_kind <= i_pwdata[ADDR_KIND_LSB +: 2];
      end
    end
  end

  cff_addr_align #(.ADDR_WIDTH(16)) u_align (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_load(addr_load),
    .i_addr(addr_in),
    .i_kind(addr_kind),
    .o_addr(aligned_addr)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB answer: one wait-free access cycle, outputs registered
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      o_pready <= 1'b0;
      o_prdata <= 32'h0;
      o_pslverr <= 1'b0;
      o_mem_addr <= 16'h0;
      o_flag_carry <= 1'b0;
    end else begin
      o_pready <= setup;
      o_pslverr <= setup && !hit;
      if (setup) begin
        o_prdata <= (!i_pwrite && hit) ? rd_value : 32'h0;
      end
      o_mem_addr <= aligned_addr;
      o_flag_carry <= flag_low[FLAG_CARRY];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  logic after_rst;
  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      after_rst <= 1'b1;
    end else begin
      after_rst <= 1'b0;
    end
  end

  user_bit_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_en && i_paddr == REG_FLAGS_OR && i_pwdata[FLAG_USER] |=> flags[FLAG_USER])
    else $error("user bit not set by or write");
  neg_sign_a: assert property (@(posedge i_clock) disable iff (i_rst)
    do_op && op == OP_ADD && sz == SZ_WORD |=> flags[FLAG_NEG] == result[15])
    else $error("negative flag differs from word sign");
  zero_flag_a: assert property (@(posedge i_clock) disable iff (i_rst)
    do_op && op == OP_SUB |=> flags[FLAG_ZERO] == (result == 32'h0))
    else $error("zero flag wrong after subtract");
  ovf_byte_a: assert property (@(posedge i_clock) disable iff (i_rst)
    do_op && op == OP_ADD && sz == SZ_BYTE |=> flags[FLAG_OVF] == ($past(operand_a[7]) == $past(operand_b[7])
      && result[7] != $past(operand_a[7])))
    else $error("byte add overflow wrong");
  carry_add_a: assert property (@(posedge i_clock) disable iff (i_rst)
    do_op && op == OP_ADD && sz == SZ_BYTE
      |=> flags[FLAG_CARRY] == (({1'b0, $past(operand_a[7:0])} + {1'b0, $past(operand_b[7:0])}) > 9'h0ff))
    else $error("byte add carry wrong");
  borrow_sub_a: assert property (@(posedge i_clock) disable iff (i_rst)
    do_op && op == OP_SUB && sz == SZ_LONG |=> flags[FLAG_CARRY] == ($past(operand_a) < $past(operand_b)))
    else $error("long subtract borrow wrong");
  shift_out_a: assert property (@(posedge i_clock) disable iff (i_rst)
    do_op && op == OP_SHL && sz == SZ_BYTE |=> flags[FLAG_CARRY] == $past(operand_a[7]) && result[0] == 1'b0)
    else $error("shift carry wrong");
  bit_acc_a: assert property (@(posedge i_clock) disable iff (i_rst)
    do_op && op == OP_BAND |=> flags[FLAG_CARRY] == ($past(cin) && $past(sel_bit)))
    else $error("bit accumulate wrong");
  bit_only_a: assert property (@(posedge i_clock) disable iff (i_rst)
    do_op && op == OP_BST |=> $countones(result[7:0] ^ $past(operand_a[7:0])) <= 1 && result[31:8] == 24'h0)
    else $error("bit store touched other bits");
  odd_align_a: assert property (@(posedge i_clock) disable iff (i_rst)
    wr_en && i_paddr == REG_ADDR_IN && i_pwdata[ADDR_KIND_LSB +: 2] == ACC_WORD ##2 1'b1
      |-> aligned_addr[0] == 1'b0 && aligned_addr[15:1] == $past(addr_in[15:1]))
    else $error("word address not forced even");
  fetch_even_a: assert property (@(posedge i_clock) disable iff (i_rst)
    addr_load && addr_kind == ACC_FETCH |=> aligned_addr[0] == 1'b0 ##1 o_mem_addr[0] == 1'b0)
    else $error("fetch address not even");
  reset_mask_a: assert property (@(posedge i_clock) disable iff (i_rst)
    after_rst |-> flag_imask)
    else $error("mask bit not set after reset");
  hold_flags_a: assert property (@(posedge i_clock) disable iff (i_rst)
    do_op && op == OP_AND |=> $stable(flag_low[FLAG_CARRY]) && flags[FLAG_OVF] == 1'b0)
    else $error("logic op disturbed carry");

  add_cover_c: cover property (@(posedge i_clock) disable iff (i_rst) do_op && op == OP_ADDX && cin);
  dec_add_cover_c: cover property (@(posedge i_clock) disable iff (i_rst)
    do_op && op == OP_DECIMAL_ADJUST_ADD && bcd_low);
  odd_cover_c: cover property (@(posedge i_clock) disable iff (i_rst) addr_load && addr_in[0]);
  err_cover_c: cover property (@(posedge i_clock) disable iff (i_rst) o_pslverr && o_pready);

endmodule : cff_flag_unit
`default_nettype wire

// File: test/cff_mem_model.sv
// Behavioural byte-wide system memory seen through the aligned address
`timescale 1ns/10ps
`default_nettype none
module cff_mem_model (
  input wire logic [15:0] i_addr,
  output logic [15:0] o_word
);
  // Each byte holds a value derived from its own address, so a wrong address shows as wrong data
  function automatic logic [7:0] byte_at(input logic [15:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h3c;
  endfunction : byte_at

  ////////////////////////////////////////////////////////////////////////////
  // The word is the byte at i_addr above the byte after it, for even and odd addresses alike
  assign o_word = {byte_at(i_addr), byte_at(i_addr + 16'h1)};
endmodule : cff_mem_model
`default_nettype wire

// File: test/cff_flag_unit_tb.sv
// Self-checking bench for the condition flag unit over APB
`timescale 1ns/10ps
`default_nettype none
module cff_flag_unit_tb;
  import cff_pkg::*;
  typedef struct {string nm; logic [31:0] d; logic [31:0] m; logic e;} cff_note_type;
  logic i_clock, i_rst, i_psel, i_penable, i_pwrite;
  logic [7:0] i_paddr;
  logic [31:0] i_pwdata, o_prdata, a, b, m, res_exp, res_mask;
  logic o_pready, o_pslverr, o_flag_carry;
  logic [15:0] o_mem_addr, mem_word, ad, ea, e1;
  logic [7:0] f;
  logic [2:0] n;
  logic [39:0] ex;
  cff_note_type notes[$];
  cff_note_type note;
  int n_errors = 0;
  int compares = 0;
  int cycles = 0;

  cff_flag_unit DUT (.i_clock(i_clock), .i_rst(i_rst), .i_psel(i_psel), .i_penable(i_penable),
    .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
    .o_prdata(o_prdata), .o_pslverr(o_pslverr), .o_mem_addr(o_mem_addr), .o_flag_carry(o_flag_carry));
  cff_mem_model mem (.i_addr(o_mem_addr), .o_word(mem_word));

  initial begin
    i_clock = 1'b0;
    forever #5 i_clock = ~i_clock;
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check

  task automatic complete_run();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : complete_run

  // One idle edge after each release, so no signal gets two assignments in one step
  task automatic apb(input logic wr, input logic [7:0] adr, input logic [31:0] wd);
    @(posedge i_clock);
    i_psel <= 1'b1;
    i_penable <= 1'b0;
    i_pwrite <= wr;
    i_paddr <= adr;
    i_pwdata <= wd;
    @(posedge i_clock);
    i_penable <= 1'b1;
    do @(posedge i_clock); while (o_pready !== 1'b1);
    i_psel <= 1'b0;
    i_penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd, input logic e);
    notes.push_back('{"write", 32'h0, 32'h0, e});
    apb(1'b1, adr, wd);
  endtask : wr

  task automatic rd(input string nm, input logic [7:0] adr, input logic [31:0] d, input logic [31:0] mk,
                    input logic e);
    notes.push_back('{nm, d, mk, e});
    apb(1'b0, adr, 32'h0);
  endtask : rd

  // Reference of result and flags; bits above the operand size are ignored
  function automatic logic [39:0] ref_op(input logic [3:0] op, input logic [1:0] sz, input logic [31:0] x,
    input logic [31:0] y, input logic [2:0] bi, input logic [7:0] fi, input logic [31:0] rp);
    int w;
    logic [32:0] s;
    logic [31:0] mk, r;
    logic c, v, upd;
    logic [7:0] fo;
    w = 8 << sz;
    mk = 32'hffffffff >> (32 - w);
    x = x & mk;
    y = y & mk;
    r = rp;
    c = fi[0];
    v = fi[1];
    upd = 1'b1;
    fo = fi;
    case (op)
      OP_ADD, OP_ADDX: begin
        s = {1'b0, x} + {1'b0, y} + ((op == OP_ADDX) ? 33'(fi[0]) : 33'h0);
        r = s[31:0] & mk;
        c = s[w];
        v = (x[w-1] == y[w-1]) && (r[w-1] != x[w-1]);
      end
      OP_SUB, OP_SUBX: begin
        s = {1'b0, x} - {1'b0, y} - ((op == OP_SUBX) ? 33'(fi[0]) : 33'h0);
        r = s[31:0] & mk;
        c = s[w];
        v = (x[w-1] != y[w-1]) && (r[w-1] != x[w-1]);
      end
      OP_AND: begin r = x & y; v = 1'b0; end
      OP_SHL: begin r = (x << 1) & mk; c = x[w-1]; v = 1'b0; end
      OP_SHR: begin r = x >> 1; c = x[0]; v = 1'b0; end
      OP_ROTL: begin r = ((x << 1) | 32'(x[w-1])) & mk; c = x[w-1]; v = 1'b0; end
      OP_ROTR: begin r = (x >> 1) | (32'(x[0]) << (w - 1)); c = x[0]; v = 1'b0; end
      OP_BLD: begin c = x[bi]; upd = 1'b0; end
      OP_BAND: begin c = c & x[bi]; upd = 1'b0; end
      OP_BOR: begin c = c | x[bi]; upd = 1'b0; end
      OP_BXOR: begin c = c ^ x[bi]; upd = 1'b0; end
      OP_BST: begin r = x & 32'hff; r[bi] = fi[0]; upd = 1'b0; end
      OP_DECIMAL_ADJUST_ADD: begin
        r = (x + ((x[3:0] > 4'h9) ? 32'h6 : 32'h0) + ((fi[0] || x > 32'h99) ? 32'h60 : 32'h0)) & 32'hff;
        c = fi[0] | (x > 32'h99);
      end
      default: r = (x - ((x[3:0] > 4'h9) ? 32'h6 : 32'h0) - (fi[0] ? 32'h60 : 32'h0)) & 32'hff;
    endcase
    if (upd) begin
      fo[3] = r[w-1];
      fo[2] = (r == 32'h0);
    end
    fo[1] = v;
    fo[0] = c;
    return {fo, r};
  endfunction : ref_op

  ////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clock) begin
    if (i_psel && i_penable && o_pready === 1'b1) begin
      note = notes.pop_front();
      check(note.nm, o_prdata & note.m, note.d & note.m);
      check("slave error", {31'h0, o_pslverr}, {31'h0, note.e});
    end
  end

  // Whole run needs about 3900 cycles
  always @(posedge i_clock) begin
    cycles++;
    if (cycles == 30000) begin
      n_errors++;
      complete_run();
    end
  end

  initial begin
    i_rst = 1'b1;
    i_psel = 1'b0;
    i_penable = 1'b0;
    i_pwrite = 1'b0;
    i_paddr = 8'h00;
    i_pwdata = 32'h0;
    res_exp = 32'h0;
    res_mask = 32'h0;
    void'($urandom(72279));
    repeat (20) @(posedge i_clock);
    i_rst <= 1'b0;
    rd("mask bit", REG_FLAGS, 32'h80, 32'h80, 1'b0);
    wr(REG_FLAGS, 32'h5a, 1'b0);
    rd("flag load", REG_FLAGS, 32'h5a, 32'hffffffff, 1'b0);
    wr(REG_FLAGS_AND, 32'hef, 1'b0);
    rd("flag and", REG_FLAGS, 32'h4a, 32'hff, 1'b0);
    wr(REG_FLAGS_OR, 32'h10, 1'b0);
    rd("flag or", REG_FLAGS, 32'h5a, 32'hff, 1'b0);
    wr(REG_FLAGS_XOR, 32'h14, 1'b0);
    rd("flag xor", REG_FLAGS, 32'h4e, 32'hff, 1'b0);
    rd("write only", REG_FLAGS_OR, 32'h0, 32'hffffffff, 1'b0);
    wr(8'h28, 32'h1, 1'b1);
    rd("unmapped", 8'h2c, 32'h0, 32'hffffffff, 1'b1);
    for (int op = 0; op < 16; op++) begin
      for (int sz = 0; sz < 3; sz++) begin
        for (int rep = 0; rep < 6; rep++) begin
          if (op >= 9 && sz != 0) continue;
          m = 32'hffffffff >> (32 - (8 << sz));
          a = $urandom;
          b = $urandom;
          f = 8'($urandom);
          n = 3'($urandom);
          if (rep == 0) begin a = m; b = 32'h1; end
          if (rep == 1) begin a = m >> 1; b = 32'h1; end
          if (rep == 2) begin a = 32'h0; b = 32'h1; end
          ex = ref_op(op[3:0], sz[1:0], a, b, n, f, res_exp);
          wr(REG_FLAGS, {24'h0, f}, 1'b0);
          wr(REG_OPERAND_A, a, 1'b0);
          wr(REG_OPERAND_B, b, 1'b0);
          wr(REG_CTRL, {21'h0, n, 2'h0, sz[1:0], op[3:0]}, 1'b0);
          if (op < 9 || op == 10 || op >= 14) begin
            res_exp = ex[31:0];
            res_mask = (op >= 9) ? 32'hff : m;
          end
          rd("result", REG_RESULT, res_exp, res_mask, 1'b0);
          rd("flags", REG_FLAGS, {24'h0, ex[39:32]}, 32'hff, 1'b0);
          check("carry pin", {31'h0, o_flag_carry}, {31'h0, ex[32]});
        end
      end
    end
    // Last launched operation was a byte decimal adjust after subtract with bit index n
    rd("control", REG_CTRL, {21'h0, n, 2'h0, SZ_BYTE, OP_DECIMAL_ADJUST_SUB}, 32'hffffffff, 1'b0);
    wr(REG_RESULT, ~res_exp, 1'b0);
    rd("read only result", REG_RESULT, res_exp, res_mask, 1'b0);
    for (int k = 0; k < 16; k++) begin
      ad = 16'($urandom);
      if (k < 8) ad[0] = 1'b1;
      ea = (k[1:0] == ACC_BYTE) ? ad : {ad[15:1], 1'b0};
      e1 = ea + 16'h1;
      wr(REG_ADDR_IN, {14'h0, k[1:0], ad}, 1'b0);
      repeat (3) @(posedge i_clock);
      rd("aligned address", REG_ADDR_OUT, {16'h0, ea}, 32'hffffffff, 1'b0);
      check("memory address", {16'h0, o_mem_addr}, {16'h0, ea});
      check("memory word", {16'h0, mem_word},
        {16'h0, ea[7:0] ^ ea[15:8] ^ 8'h3c, e1[7:0] ^ e1[15:8] ^ 8'h3c});
    end
    repeat (2) @(posedge i_clock);
    complete_run();
  end
endmodule : cff_flag_unit_tb
`default_nettype wire
